// [verilog/mie_defs.vh]
// constants for the instruction execute subset block
`ifndef MIE_DEFS_VH
`define MIE_DEFS_VH
// register map byte offsets
`define MIE_OFF_INSTR 12'h000
`define MIE_OFF_CTRL 12'h004
`define MIE_OFF_ACC 12'h008
`define MIE_OFF_STATUS 12'h00c
`define MIE_OFF_PC 12'h010
`define MIE_OFF_WDT 12'h014
`define MIE_OFF_MEMADDR 12'h018
`define MIE_OFF_MEMDATA 12'h01c
// opcode encodings in instr[19:16]
`define MIE_OP_NOP 4'h0
`define MIE_OP_BITCLR 4'h1
`define MIE_OP_WDCLR 4'h2
`define MIE_OP_WDPRE_A 4'h3
`define MIE_OP_WDPRE_B 4'h4
`define MIE_OP_CPL 4'h5
`define MIE_OP_DAA 4'h6
`define MIE_OP_DEC 4'h7
`define MIE_OP_INC 4'h8
`define MIE_OP_HALT 4'h9
`define MIE_OP_JMP 4'ha
`define MIE_OP_MOVAM 4'hb
`define MIE_OP_MOVAX 4'hc
`define MIE_OP_MOVMA 4'hd
`define MIE_OP_OR 4'he
`define MIE_OP_RET 4'hf
// instruction fields
`define MIE_F_ACCDST 20
`define MIE_F_IMM 21
`define MIE_F_RETKIND_LO 8
// status bit positions
`define MIE_ST_C 0
`define MIE_ST_AC 1
`define MIE_ST_Z 2
`define MIE_ST_OV 3
`define MIE_ST_PDF 4
`define MIE_ST_TO 5
`define MIE_ST_EMI 6
`define MIE_ST_HALT 7
`define MIE_ST_BUSY 8
// reset values
`define MIE_RST_STATUS 9'h000
`define MIE_RST_PC 11'h000
`define MIE_WDT_CLR 8'h00
// return kinds in instr[9:8]
`define MIE_RK_PLAIN 2'h0
`define MIE_RK_VALUE 2'h1
`define MIE_RK_IRQ 2'h2
`define MIE_RK_ROTL 2'h3
`endif

// [verilog/mie_ram.v]
// small data memory with registered read port
`timescale 1ns/10ps
`default_nettype none
module mie_ram #(
   parameter AW = 6,
   parameter DW = 8
) (
   // clock
   input wire clk,
   // write port
   input wire wrEn,
   input wire [AW-1:0] wrAddr,
   input wire [DW-1:0] wrData,
   // read port
   input wire [AW-1:0] rdAddr,
   output reg [DW-1:0] rdData
);
   reg [DW-1:0] mem [0:(1<<AW)-1];

   // write, with the registered read returning the data from before a same-cycle write
   always @(posedge clk) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
      rdData <= mem[rdAddr];
   end
endmodule // mie_ram
`default_nettype wire

// [verilog/mie_exec.v]
// execute unit for an 8-bit instruction subset, reached over apb
`include "mie_defs.vh"
`timescale 1ns/10ps
`default_nettype none
module mie_exec #(
   parameter AW = 6,
   parameter PCW = 11,
   parameter SD = 6
) (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // system side
   output reg clkGateOff,
   output reg wdtPrescClr,
   output reg globalIrqEnable,
   output reg [PCW-1:0] progCounter
);
   // execution states
   localparam S_IDLE = 3'd0;
   localparam S_READ = 3'd1;
   localparam S_EXEC = 3'd2;
   localparam S_RET2 = 3'd3;
   localparam S_HALT = 3'd4;
   // last stack entry, where a pop from an empty stack wraps to
   localparam [31:0] SD_LAST = SD - 1;

   reg [2:0] state_q;
   reg [21:0] instr_q;
   reg [7:0] acc_q;
   reg [8:0] status_q;
   reg [7:0] watchdogCounter_q;
   reg preA_q;
   reg preB_q;
   reg [PCW-1:0] stack_q [0:SD-1];
   reg [2:0] sp_q;
   reg ramWe;
   reg [AW-1:0] ramWa;
   reg [7:0] ramWd;
   reg [AW-1:0] ramRa;
   wire [7:0] ramRd;
   reg [AW-1:0] dbgAddr_q;
   integer i;

   // zero test shared by every zero-flag update
   function zeroOf;
      input [7:0] v;
      begin
         zeroOf = (v == 8'h00);
      end
   endfunction

   // decimal adjust of accumulator, returns {carry, result}
   function [8:0] daaOf;
      input [7:0] a;
      input ac;
      input c;
      reg [4:0] lo;
      reg ic;
      reg [4:0] hi;
      reg co;
      begin
         lo = {1'b0, a[3:0]};
         ic = 1'b0;
         if (a[3:0] > 4'h9 || ac) begin
            lo = lo + 5'h06;
            // a carry already taken out of the low nibble must not be counted twice
            ic = !ac;
         end
         hi = {1'b0, a[7:4]} + {4'h0, ic};
         co = c;
         if (hi > 5'h09 || c) begin
            hi = hi + 5'h06;
            co = 1'b1;
         end
         daaOf = {co, hi[3:0], lo[3:0]};
      end
   endfunction

   // stack pointer after a pop, wrapping like a circular stack
   function [2:0] popOf;
      input [2:0] p;
      begin
         if (p == 3'd0) begin
            popOf = SD_LAST[2:0];
         end else begin
            popOf = p - 3'd1;
         end
      end
   endfunction

   wire [3:0] op = instr_q[19:16];
   wire [AW-1:0] mAddr = instr_q[AW-1:0];
   wire [2:0] bitSel = instr_q[10:8];
   wire [7:0] imm = instr_q[15:8];
   wire toAcc = instr_q[`MIE_F_ACCDST];
   wire useImm = instr_q[`MIE_F_IMM];
   wire [1:0] retKind = instr_q[9:8];
   wire [8:0] daaRes = daaOf(acc_q, status_q[`MIE_ST_AC], status_q[`MIE_ST_C]);
   wire apbWr = psel && penable && pwrite;
   // or result shared by the accumulator and zero flag paths
   wire [7:0] orVal = acc_q | (useImm ? imm : ramRd);
   // live state bits for status reads, so a poll right after a start sees busy
   wire busyNow = (state_q != S_IDLE) && (state_q != S_HALT);
   wire haltNow = (state_q == S_HALT);
   // pop position, so an empty stack never indexes past its end
   wire [2:0] popIdx = popOf(sp_q);

   // data memory
   mie_ram #(.AW(AW), .DW(8)) i_mie_ram (
      .clk(clk),
      .wrEn(ramWe),
      .wrAddr(ramWa),
      .wrData(ramWd),
      .rdAddr(ramRa),
      .rdData(ramRd)
   );

   // memory port steering: execute writes, else debug writes
   always @* begin
      ramWe = 1'b0;
      ramWa = mAddr;
      ramWd = 8'h00;
      ramRa = (state_q == S_IDLE) ? dbgAddr_q : mAddr;
      if (state_q == S_EXEC) begin
         case (op)
            `MIE_OP_BITCLR: begin
               ramWe = 1'b1;
               ramWd = ramRd & ~(8'h01 << bitSel);
            end
            `MIE_OP_CPL: begin
               ramWe = !toAcc;
               ramWd = ~ramRd;
            end
            `MIE_OP_DAA: begin
               ramWe = 1'b1;
               ramWd = daaRes[7:0];
            end
            `MIE_OP_DEC: begin
               ramWe = !toAcc;
               ramWd = ramRd - 8'h01;
            end
            `MIE_OP_INC: begin
               ramWe = !toAcc;
               ramWd = ramRd + 8'h01;
            end
            `MIE_OP_MOVMA: begin
               ramWe = 1'b1;
               ramWd = acc_q;
            end
            `MIE_OP_OR: begin
               ramWe = !toAcc && !useImm;
               ramWd = acc_q | ramRd;
            end
            `MIE_OP_RET: begin
               ramWe = (retKind == `MIE_RK_ROTL);
               ramWd = {ramRd[6:0], ramRd[7]};
            end
            default: begin
               ramWe = 1'b0;
            end
         endcase
      end else if (state_q == S_IDLE && apbWr && paddr == `MIE_OFF_MEMDATA) begin
         ramWe = 1'b1;
         ramWa = dbgAddr_q;
         ramWd = pwdata[7:0];
      end
   end

   // apb answers and execution sequencing
   always @(posedge clk) begin
      if (!rst_n) begin
         state_q <= S_IDLE;
         instr_q <= 22'h000000;
         acc_q <= 8'h00;
         status_q <= `MIE_RST_STATUS;
         watchdogCounter_q <= `MIE_WDT_CLR;
         preA_q <= 1'b0;
         preB_q <= 1'b0;
         sp_q <= 3'd0;
         dbgAddr_q <= {AW{1'b0}};
         progCounter <= `MIE_RST_PC;
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         clkGateOff <= 1'b0;
         wdtPrescClr <= 1'b0;
         globalIrqEnable <= 1'b0;
         for (i = 0; i < SD; i = i + 1) begin
            stack_q[i] <= {PCW{1'b0}};
         end
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         wdtPrescClr <= 1'b0;
         // no wait state: answer in cycle after setup
         if (psel && !penable) begin
            pready <= 1'b1;
            pslverr <= !(paddr[11:5] == 7'h00 && paddr[1:0] == 2'b00);
            case (paddr)
               `MIE_OFF_INSTR: prdata <= {10'h000, instr_q};
               `MIE_OFF_ACC: prdata <= {24'h000000, acc_q};
               `MIE_OFF_STATUS: prdata <= {23'h000000, busyNow, haltNow, status_q[6:0]};
               `MIE_OFF_PC: prdata <= {{(32-PCW){1'b0}}, progCounter};
               `MIE_OFF_WDT: prdata <= {24'h000000, watchdogCounter_q};
               `MIE_OFF_MEMADDR: prdata <= {{(32-AW){1'b0}}, dbgAddr_q};
               `MIE_OFF_MEMDATA: prdata <= {24'h000000, ramRd};
               default: prdata <= 32'h00000000;
            endcase
         end
         if (apbWr) begin
            case (paddr)
               `MIE_OFF_INSTR: begin
                  if (state_q == S_IDLE) begin
                     instr_q <= pwdata[21:0];
                     state_q <= S_READ;
                  end
               end
               `MIE_OFF_CTRL: begin
                  // wake from power down
                  if (pwdata[0] && state_q == S_HALT) begin
                     state_q <= S_IDLE;
                     clkGateOff <= 1'b0;
                  end
                  if (pwdata[1]) begin
                     watchdogCounter_q <= watchdogCounter_q + 8'h01;
                  end
               end
               `MIE_OFF_ACC: acc_q <= pwdata[7:0];
               `MIE_OFF_STATUS: status_q[3:0] <= pwdata[3:0];
               `MIE_OFF_MEMADDR: dbgAddr_q <= pwdata[AW-1:0];
               default: ;
            endcase
         end
         case (state_q)
            S_IDLE: ;
            S_READ: state_q <= S_EXEC; // memory read latency
            S_EXEC: begin
               state_q <= S_IDLE;
               progCounter <= progCounter + {{(PCW-1){1'b0}}, 1'b1};
               case (op)
                  // watchdog clears; a preclear waits for its partner
                  `MIE_OP_WDCLR: begin
                     watchdogCounter_q <= `MIE_WDT_CLR;
                     status_q[`MIE_ST_PDF] <= 1'b0;
                     status_q[`MIE_ST_TO] <= 1'b0;
                  end
                  `MIE_OP_WDPRE_A, `MIE_OP_WDPRE_B: begin
                     if ((op == `MIE_OP_WDPRE_A && preB_q) ||
                         (op == `MIE_OP_WDPRE_B && preA_q)) begin
                        watchdogCounter_q <= `MIE_WDT_CLR;
                        status_q[`MIE_ST_PDF] <= 1'b0;
                        status_q[`MIE_ST_TO] <= 1'b0;
                        preA_q <= 1'b0;
                        preB_q <= 1'b0;
                     end else if (op == `MIE_OP_WDPRE_A) begin
                        preA_q <= 1'b1;
                     end else begin
                        preB_q <= 1'b1;
                     end
                  end
                  // data operations on the memory operand, zero flag only; daa adjusts the accumulator into memory and sets carry only
                  `MIE_OP_CPL: begin
                     if (toAcc) acc_q <= ~ramRd;
                     status_q[`MIE_ST_Z] <= zeroOf(~ramRd);
                  end
                  `MIE_OP_DAA: status_q[`MIE_ST_C] <= daaRes[8];
                  `MIE_OP_DEC: begin
                     if (toAcc) acc_q <= ramRd - 8'h01;
                     status_q[`MIE_ST_Z] <= zeroOf(ramRd - 8'h01);
                  end
                  `MIE_OP_INC: begin
                     if (toAcc) acc_q <= ramRd + 8'h01;
                     status_q[`MIE_ST_Z] <= zeroOf(ramRd + 8'h01);
                  end
                  // power down clears the watchdog counter and prescaler, sets pdf, clears to and stops the clock
                  `MIE_OP_HALT: begin
                     state_q <= S_HALT;
                     clkGateOff <= 1'b1;
                     watchdogCounter_q <= `MIE_WDT_CLR;
                     wdtPrescClr <= 1'b1;
                     status_q[`MIE_ST_PDF] <= 1'b1;
                     status_q[`MIE_ST_TO] <= 1'b0;
                  end
                  // flow control and moves leave every flag alone; or sets the zero flag
                  `MIE_OP_JMP: progCounter <= instr_q[PCW-1:0];
                  `MIE_OP_MOVAM: acc_q <= ramRd;
                  `MIE_OP_MOVAX: acc_q <= imm;
                  `MIE_OP_OR: begin
                     if (toAcc || useImm) acc_q <= orVal;
                     status_q[`MIE_ST_Z] <= zeroOf(orVal);
                  end
                  // returns share one opcode; kind three is the one-cycle rotate
                  `MIE_OP_RET: begin
                     if (retKind != `MIE_RK_ROTL) begin
                        // pop, second cycle follows
                        state_q <= S_RET2;
                        progCounter <= stack_q[popIdx];
                        sp_q <= popIdx;
                        if (retKind == `MIE_RK_VALUE) acc_q <= instr_q[7:0];
                        if (retKind == `MIE_RK_IRQ) globalIrqEnable <= 1'b1;
                     end
                  end
                  default: ; // untouched flags keep value
               endcase
            end
            S_RET2: state_q <= S_IDLE;
            S_HALT: ;
            default: state_q <= S_IDLE;
         endcase
         status_q[`MIE_ST_EMI] <= globalIrqEnable;
         // timeout event after the execute case, so it wins over a clear in one cycle
         if (apbWr && paddr == `MIE_OFF_CTRL && pwdata[2]) begin
            status_q[`MIE_ST_TO] <= 1'b1;
         end
      end
   end
endmodule // mie_exec
`default_nettype wire

// [verif/mie_exec_props.sv]
// port assertions for the execute block
`timescale 1ns/10ps
`default_nettype none
module mie_exec_props #(
   parameter PCW = 11
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // system side
   input wire logic clkGateOff,
   input wire logic wdtPrescClr,
   input wire logic globalIrqEnable,
   input wire logic [PCW-1:0] progCounter
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // bus answer timing and decode
   chk_ready_first: assert property (psel && !penable ##1 psel && penable |-> pready)
      else $error("no ready in first access cycle");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   chk_ready_access: assert property (pready |-> psel && penable)
      else $error("ready outside access phase");
   chk_err_decode: assert property (pready |-> pslverr == (paddr > 12'h01c || paddr[1:0] != 2'h0))
      else $error("error response does not match decode");
   chk_err_rdzero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read returned data");
   // power down side effects and sticky interrupt enable
   chk_presc_pulse: assert property (wdtPrescClr |=> !wdtPrescClr)
      else $error("prescaler clear not a pulse");
   chk_presc_gate: assert property (wdtPrescClr |-> ##[0:2] clkGateOff)
      else $error("prescaler clear without power down");
   chk_pc_frozen: assert property (clkGateOff ##1 clkGateOff |-> $stable(progCounter))
      else $error("program counter moved while halted");
   chk_irq_sticky: assert property (globalIrqEnable |=> globalIrqEnable)
      else $error("interrupt enable dropped");
   // main scenarios
   cov_halt: cover property ($rose(clkGateOff));
   cov_refused: cover property (pready && pslverr);
   cov_irq: cover property ($rose(globalIrqEnable));
endmodule // mie_exec_props
bind mie_exec mie_exec_props #(.PCW(PCW)) i_mie_exec_props (.clk(clk), .rst_n(rst_n),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .clkGateOff(clkGateOff),
   .wdtPrescClr(wdtPrescClr), .globalIrqEnable(globalIrqEnable),
   .progCounter(progCounter));
`default_nettype wire

// [verif/mie_sys_model.sv]
// far-side model of the watchdog prescaler controller
`timescale 1ns/10ps
`default_nettype none
module mie_sys_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // requests from the execute block
   input wire logic wdtPrescClr,
   // observed state
   output logic [7:0] presClrCount
);
   // prescaler restarts on each clear request; count them
   always @(posedge clk) begin
      if (!rst_n) begin
         presClrCount <= 8'h00;
      end else if (wdtPrescClr) begin
         presClrCount <= presClrCount + 8'h01;
      end
   end
endmodule // mie_sys_model
`default_nettype wire

// [verif/tb.sv]
// self-checking bench for the execute block
`timescale 1ns/10ps
`default_nettype none
`include "mie_defs.vh"
module tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   wire [31:0] prdata;
   wire pready;
   wire pslverr;
   wire clkGateOff;
   wire wdtPrescClr;
   wire globalIrqEnable;
   wire [10:0] progCounter;
   wire [7:0] presClrCount;
   int errors = 0;
   int checked = 0;
   logic [31:0] rdv;
   logic rdErr;
   logic [10:0] pc;
   logic [51:0] r;
   // acc, op, dest, x, mem in, result, to acc, flags in, flags out
   logic [51:0] rows [0:17] = '{52'h33_1_0_07_80_00_0_b_b, 52'h33_5_0_00_5a_a5_0_f_b,
      52'h33_5_1_00_ff_00_1_b_f, 52'h33_7_0_00_01_00_0_b_f, 52'h33_7_1_00_00_ff_1_f_b,
      52'h33_8_0_00_ff_00_0_0_4, 52'h33_8_1_00_7f_80_1_4_0, 52'h33_e_1_00_44_77_1_4_0,
      52'h00_e_0_00_00_00_0_b_f, 52'h33_e_3_c0_55_f3_1_f_b, 52'h33_f_0_03_81_03_0_4_4,
      52'h55_b_0_00_00_00_1_b_b, 52'h55_c_0_7e_11_7e_1_0_0, 52'h3c_d_0_00_99_3c_0_f_f,
      52'h9a_6_0_00_11_00_0_0_1, 52'h45_6_0_00_11_a5_0_1_1, 52'h33_0_0_00_42_42_0_f_f,
      52'h32_6_0_00_11_38_0_2_2};
   always #10 clk = ~clk;
   mie_exec i_mie_exec (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .clkGateOff(clkGateOff), .wdtPrescClr(wdtPrescClr),
      .globalIrqEnable(globalIrqEnable), .progCounter(progCounter));
   mie_sys_model i_mie_sys_model (.clk(clk), .rst_n(rst_n), .wdtPrescClr(wdtPrescClr),
      .presClrCount(presClrCount));
   // verdict and end of run
   task close_out;
      if (errors == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // compare one value
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one apb transfer; psel stays up so the next setup may follow at once
   task xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      @(posedge clk);
      while (pready !== 1'b1 && n < 40) begin
         n++;
         @(posedge clk);
      end
      chk({31'h0, pready}, 32'h1);
      rdv = prdata;
      rdErr = pslverr;
      penable <= 1'b0;
   endtask
   // issue an instruction and poll until busy drops; rdv ends as status
   task exec(input logic [31:0] ins);
      int n;
      xfer(`MIE_OFF_INSTR, 1'b1, ins);
      n = 0;
      rdv = 32'h100;
      while (rdv[8] !== 1'b0 && n < 20) begin
         xfer(`MIE_OFF_STATUS, 1'b0, 32'h0);
         n++;
      end
      chk({31'h0, rdv[8]}, 32'h0);
   endtask
   function automatic logic [31:0] mk(input logic [3:0] op, input logic [1:0] f,
      input logic [7:0] x, input logic [7:0] lo);
      mk = {10'h000, f, op, x, lo};
   endfunction
   // hang guard
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      close_out();
   end
   // main sequence
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      chk({21'h0, progCounter}, 32'h0);
      chk({30'h0, clkGateOff, globalIrqEnable}, 32'h0);
      xfer(`MIE_OFF_STATUS, 1'b0, 32'h0);
      chk(rdv, {23'h0, `MIE_RST_STATUS});
      // data and flag operations from the table
      for (int i = 0; i < 18; i++) begin
         r = rows[i];
         pc = progCounter;
         xfer(`MIE_OFF_MEMADDR, 1'b1, 32'h9);
         xfer(`MIE_OFF_MEMDATA, 1'b1, {24'h0, r[27:20]});
         xfer(`MIE_OFF_ACC, 1'b1, {24'h0, r[51:44]});
         xfer(`MIE_OFF_STATUS, 1'b1, {28'h0, r[7:4]});
         exec(mk(r[43:40], r[37:36], r[35:28], 8'h09));
         chk({25'h0, rdv[6:0]}, {28'h0, r[3:0]});
         xfer(`MIE_OFF_ACC, 1'b0, 32'h0);
         chk(rdv, {24'h0, r[8] ? r[19:12] : r[51:44]});
         xfer(`MIE_OFF_MEMDATA, 1'b0, 32'h0);
         chk(rdv, {24'h0, r[8] ? r[27:20] : r[19:12]});
         chk({21'h0, progCounter}, {21'h0, pc + 11'h1});
      end
      // jump and the three return forms
      xfer(`MIE_OFF_STATUS, 1'b1, 32'hf);
      exec(mk(`MIE_OP_JMP, 2'h0, 8'h05, 8'ha5));
      chk({21'h0, progCounter}, 32'h5a5);
      exec(mk(`MIE_OP_RET, 2'h0, 8'h00, 8'h00));
      chk({21'h0, progCounter}, 32'h0);
      exec(mk(`MIE_OP_JMP, 2'h0, 8'h03, 8'h11));
      exec(mk(`MIE_OP_RET, 2'h0, 8'h01, 8'h9c));
      chk({21'h0, progCounter}, 32'h0);
      xfer(`MIE_OFF_ACC, 1'b0, 32'h0);
      chk(rdv, 32'h9c);
      exec(mk(`MIE_OP_RET, 2'h0, 8'h02, 8'h00));
      chk({25'h0, rdv[6:0]}, 32'h4f);
      chk({31'h0, globalIrqEnable}, 32'h1);
      // power down, a refused instruction, then wake
      xfer(`MIE_OFF_CTRL, 1'b1, 32'h6);
      pc = progCounter;
      exec(mk(`MIE_OP_HALT, 2'h0, 8'h00, 8'h00));
      chk({28'h0, rdv[7:4]}, 32'hd);
      chk({20'h0, clkGateOff, progCounter}, {20'h1, pc + 11'h1});
      chk({24'h0, presClrCount}, 32'h1);
      xfer(`MIE_OFF_WDT, 1'b0, 32'h0);
      chk(rdv, 32'h0);
      exec(mk(`MIE_OP_NOP, 2'h0, 8'h00, 8'h00));
      chk({21'h0, progCounter}, {21'h0, pc + 11'h1});
      xfer(`MIE_OFF_CTRL, 1'b1, 32'h1);
      // single clear, lone preclear, completed pair
      xfer(`MIE_OFF_CTRL, 1'b1, 32'h6);
      exec(mk(`MIE_OP_WDCLR, 2'h0, 8'h00, 8'h00));
      chk({26'h0, rdv[5:0]}, 32'hf);
      xfer(`MIE_OFF_WDT, 1'b0, 32'h0);
      chk(rdv, 32'h0);
      xfer(`MIE_OFF_CTRL, 1'b1, 32'h6);
      exec(mk(`MIE_OP_WDPRE_A, 2'h0, 8'h00, 8'h00));
      exec(mk(`MIE_OP_WDPRE_A, 2'h0, 8'h00, 8'h00));
      chk({30'h0, rdv[5:4]}, 32'h2);
      xfer(`MIE_OFF_WDT, 1'b0, 32'h0);
      chk(rdv, 32'h1);
      exec(mk(`MIE_OP_WDPRE_B, 2'h0, 8'h00, 8'h00));
      chk({30'h0, rdv[5:4]}, 32'h0);
      xfer(`MIE_OFF_WDT, 1'b0, 32'h0);
      chk(rdv, 32'h0);
      chk({31'h0, clkGateOff}, 32'h0);
      // unmapped and unaligned places
      xfer(12'h020, 1'b0, 32'h0);
      chk({rdErr, rdv[30:0]}, 32'h80000000);
      xfer(12'h006, 1'b1, 32'h0);
      chk({31'h0, rdErr}, 32'h1);
      psel <= 1'b0;
      repeat (4) @(posedge clk);
      close_out();
   end
endmodule // tb
`default_nettype wire
